// ===== adc_result_formatter.sv
// Result formatter: APB registers, justification and acquisition guard
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Left format puts value bits 9:2 into the whole high register.
// - Left format puts value bits 1:0 into low register bits 7:6.
// - Left format leaves low register bits 5:0 reserved (zero).
// - Right format puts bits 9:8 in high bits 1:0, bits 7:2 reserved.
// - Right format puts value bits 7:0 into the whole low register.
// - Result registers are read-write and only power-on reset clears them.
module adc_result_formatter
  import adc_result_pkg::*;
(
  input  wire logic                      ref_clk,    // System clock
  input  wire logic                      rstn,       // Other resets, async low
  input  wire logic                      porRstn,    // Power-on/brown-out
  input  wire logic                      psel,       // APB select
  input  wire logic                      penable,    // APB enable
  input  wire logic                      pwrite,     // APB direction
  input  wire logic [11:0]               paddr,      // APB byte address
  input  wire logic [31:0]               pwdata,     // APB write data
  output logic                           pready,     // APB ready
  output logic [31:0]                    prdata,     // APB read data
  output logic                           pslverr,    // APB error
  input  wire adc_result_pkg::conv_result_t convIn,  // Engine result
  input  wire logic                      startReq,   // Conversion request
  output logic                           startGo,    // Granted start pulse
  output logic [4:0]                     channelSel  // Selected channel
);
  // Reset synchronisers; result registers only see the power-on one
  logic [1:0] rstSync_q;
  logic [1:0] porSync_q;
  logic       rstSyncN;
  logic       porSyncN;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rstSync_q <= 2'b00;
    else       rstSync_q <= {rstSync_q[0], 1'b1};
  end
  always_ff @(posedge ref_clk or negedge porRstn) begin
    if (!porRstn) porSync_q <= 2'b00;
    else          porSync_q <= {porSync_q[0], 1'b1};
  end
  assign rstSyncN = rstSync_q[1];
  assign porSyncN = porSync_q[1];

  // APB access strobes; single-cycle access phase
  logic access;
  logic wrAcc;
  assign access  = psel & penable;
  assign wrAcc   = access & pwrite;
  assign pready  = 1'b1;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == OffResultHigh) || (a == OffResultLow) ||
             (a == OffControl) || (a == OffStatus);
  endfunction
  assign pslverr = access & ~mapped(paddr);

  // Control register: justify select and channel
  logic [31:0] control_q;
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      control_q <= ControlReset;
    end else if (wrAcc && paddr == OffControl) begin
      control_q <= {26'h000_0000, pwdata[5:0]};
    end
  end
  assign channelSel = control_q[ChannelLsb +: ChannelWidth];

  // Channel change restarts the acquisition counter
  logic        chanChange;
  logic [10:0] acqCnt_q;
  logic        acqBusy;
  assign chanChange = wrAcc && paddr == OffControl &&
                      pwdata[ChannelLsb +: ChannelWidth] != channelSel;
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      acqCnt_q <= 11'h000;
    end else if (chanChange) begin
      acqCnt_q <= 11'(AcqCycles);
    end else if (acqCnt_q != 11'h000) begin
      acqCnt_q <= acqCnt_q - 11'h001;
    end
  end
  assign acqBusy = acqCnt_q != 11'h000;
  // Starts are held off while acquiring; a refused request is dropped
  assign startGo = startReq & ~acqBusy & ~chanChange;

  // Formatting of the incoming conversion
  result_pair_t fmt;
  adc_result_layout u_layout (
    .justifySelect   (control_q[JustifyBit]),
    .conversionValue (convIn.value),
    .pair            (fmt)
  );

  // Result registers: engine update wins over a software write
  logic [7:0] resultHigh_q;
  logic [7:0] resultLow_q;
  always_ff @(posedge ref_clk or negedge porSyncN) begin
    if (!porSyncN) begin
      resultHigh_q <= ResultReset;
      resultLow_q  <= ResultReset;
    end else if (convIn.valid) begin
      resultHigh_q <= fmt.high;
      resultLow_q  <= fmt.low;
    end else if (wrAcc && paddr == OffResultHigh) begin
      resultHigh_q <= pwdata[7:0];
    end else if (wrAcc && paddr == OffResultLow) begin
      resultLow_q  <= pwdata[7:0];
    end
  end

  // Read word is taken into a flip-flop in the setup cycle, so the access
  // phase shows registered data with no wait state; limitation: a result
  // landing on that same edge only shows up on the next read
  logic [31:0] readMux;
  logic [31:0] readData_q;
  always_comb begin
    if (paddr == OffResultHigh) begin
      readMux = {24'h00_0000, resultHigh_q};
    end else if (paddr == OffResultLow) begin
      readMux = {24'h00_0000, resultLow_q};
    end else if (paddr == OffControl) begin
      readMux = control_q;
    end else if (paddr == OffStatus) begin
      readMux = {31'h0000_0000, acqBusy};
    end else begin
      readMux = 32'h0000_0000;
    end
  end
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      readData_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      readData_q <= readMux;
    end
  end
  assign prdata = readData_q;

  // Cycles since the last channel change, saturating; kept apart from the
  // down-counter so an off-by-one in either one trips the checks below
  logic [10:0] sinceChange_q;
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sinceChange_q <= 11'h7FF;
    end else if (chanChange) begin
      sinceChange_q <= 11'h000;
    end else if (sinceChange_q != 11'h7FF) begin
      sinceChange_q <= sinceChange_q + 11'h001;
    end
  end

  // Checks; result checks only stop for the power-on reset, so the
  // other reset is shown to leave the results alone
  a_left_high: assert property (
    @(posedge ref_clk) disable iff (!porSyncN)
    convIn.valid && !control_q[JustifyBit] |=>
      resultHigh_q == $past(convIn.value[9:2]))
    else $error("left high byte wrong");
  a_left_low: assert property (
    @(posedge ref_clk) disable iff (!porSyncN)
    convIn.valid && !control_q[JustifyBit] |=>
      resultLow_q[7:6] == $past(convIn.value[1:0]))
    else $error("left low bits wrong");
  a_left_reserved: assert property (
    @(posedge ref_clk) disable iff (!porSyncN)
    convIn.valid && !control_q[JustifyBit] |=>
      resultLow_q[5:0] == 6'h00)
    else $error("left reserved not zero");
  a_right_high: assert property (
    @(posedge ref_clk) disable iff (!porSyncN)
    convIn.valid && control_q[JustifyBit] |=>
      resultHigh_q == {6'h00, $past(convIn.value[9:8])})
    else $error("right high byte wrong");
  a_right_low: assert property (
    @(posedge ref_clk) disable iff (!porSyncN)
    convIn.valid && control_q[JustifyBit] |=>
      resultLow_q == $past(convIn.value[7:0]))
    else $error("right low byte wrong");
  a_sw_write: assert property (
    @(posedge ref_clk) disable iff (!porSyncN)
    wrAcc && paddr == OffResultLow && !convIn.valid |=>
      resultLow_q == $past(pwdata[7:0]))
    else $error("low write lost");
  a_sw_write_high: assert property (
    @(posedge ref_clk) disable iff (!porSyncN)
    wrAcc && paddr == OffResultHigh && !convIn.valid |=>
      resultHigh_q == $past(pwdata[7:0]))
    else $error("high write lost");
  a_result_hold: assert property (
    @(posedge ref_clk) disable iff (!porSyncN)
    !convIn.valid &&
      !(wrAcc && (paddr == OffResultHigh || paddr == OffResultLow)) |=>
      $stable(resultHigh_q) && $stable(resultLow_q))
    else $error("result changed without cause");
  a_acq_guard: assert property (
    @(posedge ref_clk) disable iff (!rstSyncN)
    chanChange |=> !startGo [*8])
    else $error("start during acquisition");
  a_acq_end: assert property (
    @(posedge ref_clk) disable iff (!rstSyncN)
    sinceChange_q >= 11'(AcqCycles) |-> !acqBusy)
    else $error("acquisition never ends");
  a_acq_busy: assert property (
    @(posedge ref_clk) disable iff (!rstSyncN)
    sinceChange_q < 11'(AcqCycles) |-> acqBusy)
    else $error("acquisition cut short");
  a_acq_hold: assert property (
    @(posedge ref_clk) disable iff (!rstSyncN)
    startGo |-> sinceChange_q >= 11'(AcqCycles))
    else $error("start granted too early");
  a_chan_load: assert property (
    @(posedge ref_clk) disable iff (!rstSyncN)
    wrAcc && paddr == OffControl |=>
      channelSel == $past(pwdata[ChannelLsb +: ChannelWidth]))
    else $error("channel not loaded");
  a_pair_update: assert property (
    @(posedge ref_clk) disable iff (!porSyncN)
    convIn.valid |=> {resultHigh_q, resultLow_q} == $past(fmt))
    else $error("halves not updated together");
endmodule // adc_result_formatter
`default_nettype wire

// ===== adc_result_formatter_tb_top.sv
// Self-checking bench for the result formatter over APB
`timescale 1ns/1ps
`default_nettype none
module adc_result_formatter_tb_top;
  import adc_result_pkg::*;
  logic         ref_clk, rstn, porRstn, psel, penable, pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         pready, pslverr, startReq, startGo, e;
  logic [4:0]   channelSel;
  conv_result_t convIn;
  int           errors, tests_run, waitCnt;

  adc_result_formatter adc_result_formatter_i (
    .ref_clk(ref_clk), .rstn(rstn), .porRstn(porRstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .convIn(convIn),
    .startReq(startReq), .startGo(startGo), .channelSel(channelSel));

  // System clock, 5 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t flag %b, expected %b", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] r,
                     output logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rd, e);
    chk32(rd, exp);
  endtask

  // Engine result: one-cycle valid pulse, then an idle cycle
  task automatic conv(input logic [9:0] v);
    @(posedge ref_clk);
    convIn <= '{valid: 1'b1, value: v};
    @(posedge ref_clk);
    convIn.valid <= 1'b0;
  endtask

  // Reset held 16 cycles; por also hits the power-on domain
  task automatic pulseReset(input logic por);
    @(posedge ref_clk);
    rstn <= 1'b0;
    if (por) porRstn <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    porRstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  // Main sequence
  initial begin
    rstn      <= 1'b0;
    porRstn   <= 1'b0;
    psel      <= 1'b0;
    penable   <= 1'b0;
    pwrite    <= 1'b0;
    paddr     <= '0;
    pwdata    <= '0;
    convIn    <= '0;
    startReq  <= 1'b0;
    errors    = 0;
    tests_run = 0;
    pulseReset(1'b1);
    rdc(OffResultHigh, 32'h0000_0000);
    conv(10'h155); // Overwritten at once by the next conversion
    conv(10'h2B6);
    rdc(OffResultHigh, 32'h0000_00AD);
    rdc(OffResultLow, 32'h0000_0080);
    conv(10'h3FF);
    rdc(OffResultLow, 32'h0000_00C0);
    wr(OffControl, 32'h0000_0001);
    conv(10'h2B6);
    rdc(OffResultHigh, 32'h0000_0002);
    rdc(OffResultLow, 32'h0000_00B6);
    wr(OffResultHigh, 32'h0000_005A);
    wr(OffResultLow, 32'h0000_00A5);
    rdc(OffResultHigh, 32'h0000_005A);
    rdc(OffResultLow, 32'h0000_00A5);
    pulseReset(1'b0); // Other reset keeps results, clears control
    rdc(OffResultHigh, 32'h0000_005A);
    rdc(OffResultLow, 32'h0000_00A5);
    rdc(OffControl, ControlReset);
    apb(1'b0, 12'h010, 32'h0000_0000, rd, e);
    chkBit(e, 1'b1);
    chk32(rd, 32'h0000_0000);
    // Channel change: starts held off for the acquisition period
    startReq <= 1'b1;
    wr(OffControl, 32'h0000_0006);
    // The channel register settles after the access edge, so look later
    @(negedge ref_clk);
    chk32({27'h000_0000, channelSel}, 32'h0000_0003);
    rdc(OffStatus, 32'h0000_0001);
    waitCnt = 3;
    while (startGo !== 1'b1 && waitCnt < 1100) begin
      @(negedge ref_clk);
      waitCnt++;
    end
    chkBit(waitCnt inside {[AcqCycles - 2:AcqCycles + 3]}, 1'b1);
    rdc(OffStatus, 32'h0000_0000);
    // Conversion only once the acquisition has run its course
    conv(10'h0F3);
    rdc(OffResultHigh, 32'h0000_003C);
    rdc(OffResultLow, 32'h0000_00C0);
    pulseReset(1'b1);
    rdc(OffResultLow, 32'h0000_0000);
    conclude();
  end

  // Watchdog cuts a hang short; the run needs about 1130 cycles
  initial begin
    #20000;
    errors++;
    conclude();
  end
endmodule // adc_result_formatter_tb_top
`default_nettype wire

// ===== adc_result_layout.sv
// Combinational placement of a conversion value into the two result bytes
`timescale 1ns/1ps
`default_nettype none
module adc_result_layout
  import adc_result_pkg::*;
(
  input  wire logic                  justifySelect, // 1 right, 0 left
  input  wire logic [9:0]            conversionValue, // Raw result
  output var adc_result_pkg::result_pair_t pair     // Formatted bytes
);
  // Reserved bits are filled with zero
  always_comb begin
    if (justifySelect) begin
      pair.high = {6'h00, conversionValue[9:8]};
      pair.low  = conversionValue[7:0];
    end else begin
      pair.high = conversionValue[9:2];
      pair.low  = {conversionValue[1:0], 6'h00};
    end
  end
endmodule // adc_result_layout
`default_nettype wire

// ===== adc_result_pkg.sv
// Package: register map, field layout and timing constants for result formatter
package adc_result_pkg;
  localparam int          ResultWidth  = 10;
  localparam int          RegWidth     = 8;
  localparam logic [11:0] OffResultHigh = 12'h000;
  localparam logic [11:0] OffResultLow  = 12'h004;
  localparam logic [11:0] OffControl    = 12'h008;
  localparam logic [11:0] OffStatus     = 12'h00C;
  localparam int          JustifyBit    = 0;
  localparam int          ChannelLsb    = 1;
  localparam int          ChannelWidth  = 5;
  localparam int          AcqBusyBit    = 0;
  localparam int          AcqTimeNs     = 5000;
  localparam int          ClockPeriodNs = 5;
  localparam int          AcqCycles     = AcqTimeNs / ClockPeriodNs;
  localparam logic [31:0] ControlReset  = 32'h0000_0000;
  localparam logic [7:0]  ResultReset   = 8'h00;

  typedef struct packed {
    logic        valid;
    logic [9:0]  value;
  } conv_result_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_pair_t;
endpackage
